// File: verilog/dpc_top.sv
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "dpc_params.svh"
module dpc_top (
    input  wire logic        pclk,          // 25 MHz clock
    input  wire logic        presetn,       // Async reset, low
    input  wire logic        ce,            // Clock enable
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB direction
    input  wire logic [11:0] paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire logic        xfer,          // Bus transfer done
    input  wire logic [2:0]  xfer_bytes,    // Bytes in transfer, 1 to 4
    input  wire logic        trigger,       // Trigger event
    input  wire logic [7:0]  rd_byte,       // Last byte read from source
    output logic             pat_match,     // Registered match pulse
    output logic             cell_complete, // Registered full-cell pulse
    output logic [7:0]       match_byte_o   // Match byte to datapath
);
    import dpc_pkg::*;
    dpc_regs_type r_r;
    dpc_regs_type r_nxt;
    logic         pm_r;
    logic         cc_r;
    logic         hit;
    dpc_step_if   st ();

    function automatic logic [31:0] zext16(input logic [15:0] v);
        zext16 = {16'h0000, v};
    endfunction

    // Match only in pattern mode; byte loaded beforehand by software
    assign hit = r_r.pat_mode && xfer && (rd_byte == r_r.match_byte);
    assign st.xfer = xfer;
    assign st.xfer_bytes = xfer_bytes;
    assign st.trigger = trigger;
    assign st.match = hit;
    assign st.cell_size = r_r.bytes_per_event;

    dpc_ptr_track u_trk (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .st      (st)
    );

    always_comb begin
        r_nxt = r_r;
        r_nxt.pready = 1'b0;
        r_nxt.pslverr = 1'b0;
        // One wait state: answer in the cycle after the first access cycle
        if (psel && penable && !r_r.pready) begin
            r_nxt.pready = 1'b1;
            r_nxt.prdata = 32'h0000_0000;
            if (paddr == `DPC_OFS_SRC_PTR) begin
                r_nxt.prdata = zext16(st.src_ptr);
            end else if (paddr == `DPC_OFS_DST_PTR) begin
                r_nxt.prdata = zext16(st.dst_ptr);
            end else if (paddr == `DPC_OFS_CELL_SIZE) begin
                r_nxt.prdata = zext16(r_r.bytes_per_event);
                if (pwrite) begin
                    r_nxt.bytes_per_event = pwdata[15:0];
                end
            end else if (paddr == `DPC_OFS_CELL_PROG) begin
                r_nxt.prdata = zext16(st.cell_prog);
            end else if (paddr == `DPC_OFS_MATCH) begin
                r_nxt.prdata = {24'h00_0000, r_r.match_byte};
                if (pwrite) begin
                    r_nxt.match_byte = pwdata[`DPC_MATCH_W-1:0];
                end
            end else if (paddr == `DPC_OFS_CTRL) begin
                r_nxt.prdata = {31'h0000_0000, r_r.pat_mode};
                if (pwrite) begin
                    r_nxt.pat_mode = pwdata[`DPC_CTRL_PAT_BIT];
                end
            end else begin
                r_nxt.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_r <= '0;
            pm_r <= 1'b0;
            cc_r <= 1'b0;
        end else if (ce) begin
            r_r <= r_nxt;
            pm_r <= hit;
            cc_r <= st.cell_done;
        end
    end

    assign prdata = r_r.prdata;
    assign pready = r_r.pready;
    assign pslverr = r_r.pslverr;
    assign pat_match = pm_r;
    assign cell_complete = cc_r;
    assign match_byte_o = r_r.match_byte;

    chk_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pready && paddr <= `DPC_OFS_CELL_PROG |-> prdata[31:16] == 16'h0000)
        else $error("upper bits not zero");
    chk_size_write: assert property (@(posedge pclk) disable iff (!presetn)
        ce && psel && penable && pwrite && !pready && paddr == `DPC_OFS_CELL_SIZE
        |=> r_r.bytes_per_event == $past(pwdata[15:0]))
        else $error("cell size not written");
    chk_no_match_off: assert property (@(posedge pclk) disable iff (!presetn)
        !r_r.pat_mode |-> !hit)
        else $error("match outside pattern mode");
    cov_rd: cover property (@(posedge pclk) disable iff (!presetn) pready && !pwrite);
    cov_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule

// File: verilog/dpc_params.svh
// Summary of operation
// - The block keeps a 16-bit read-only source byte pointer whose value is the next source byte offset.
// - The block keeps a 16-bit read-only destination byte pointer whose value is the destination byte offset.
// - The writable cell size sets the bytes moved per trigger event, with zero meaning 65,536 bytes.
// - The read-only cell progress counter reports bytes moved in the current cell, cleared by a full cell or by a trigger event in a cycle without a transfer.
// - In pattern detect mode a pattern match clears the source pointer and the cell progress counter.
// - Bits 31 to 16 of the pointer, cell size and progress registers read zero and ignore writes.
`ifndef DPC_PARAMS_SVH
`define DPC_PARAMS_SVH
`define DPC_OFS_SRC_PTR   12'h000
`define DPC_OFS_DST_PTR   12'h004
`define DPC_OFS_CELL_SIZE 12'h008
`define DPC_OFS_CELL_PROG 12'h00C
`define DPC_OFS_MATCH     12'h010
`define DPC_OFS_CTRL      12'h014
`define DPC_CTRL_PAT_BIT  0
`define DPC_RESET_VAL     16'h0000
`define DPC_MATCH_W       8
`endif

// File: verilog/dpc_pkg.sv
package dpc_pkg;
    typedef logic [15:0] dpc_cnt_type;
    typedef struct packed {
        logic [15:0] src_ptr;
        logic [15:0] dst_ptr;
        logic [15:0] cell_prog;
    } dpc_ptr_type;
    typedef struct packed {
        logic [15:0] bytes_per_event;
        logic [7:0]  match_byte;
        logic        pat_mode;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } dpc_regs_type;
endpackage

// File: verilog/dpc_step_if.sv
`timescale 1ns/1ps
interface dpc_step_if;
    logic        xfer;       // One bus transfer done
    logic [2:0]  xfer_bytes; // Bytes in that transfer
    logic        trigger;    // Trigger event
    logic        match;      // Pattern seen, pattern mode on
    logic [15:0] cell_size;  // Bytes per event
    logic [15:0] src_ptr;
    logic [15:0] dst_ptr;
    logic [15:0] cell_prog;
    logic        cell_done;  // Full cell moved
    modport ctl (output xfer, xfer_bytes, trigger, match, cell_size, input src_ptr, dst_ptr, cell_prog, cell_done);
    modport cnt (input xfer, xfer_bytes, trigger, match, cell_size, output src_ptr, dst_ptr, cell_prog, cell_done);
endinterface

// File: verilog/dpc_ptr_track.sv
`timescale 1ns/1ps
`include "dpc_params.svh"
module dpc_ptr_track (
    input  wire logic pclk,    // Clock
    input  wire logic presetn, // Async reset, low
    input  wire logic ce,      // Clock enable
    dpc_step_if.cnt   st       // Step inputs and counts
);
    import dpc_pkg::*;
    dpc_ptr_type s_r;
    dpc_ptr_type s_nxt;
    logic [16:0] cell_bytes;
    logic [16:0] prog_sum;

    always_comb begin
        s_nxt = s_r;
        cell_bytes = (st.cell_size == 16'h0000) ? 17'h1_0000 : {1'b0, st.cell_size};
        prog_sum = {1'b0, s_r.cell_prog} + {14'h0000, st.xfer_bytes};
        if (st.trigger) begin
            s_nxt.cell_prog = `DPC_RESET_VAL;
        end
        if (st.xfer) begin
            s_nxt.src_ptr = s_r.src_ptr + {13'h0000, st.xfer_bytes};
            s_nxt.dst_ptr = s_r.dst_ptr + {13'h0000, st.xfer_bytes};
            s_nxt.cell_prog = (prog_sum >= cell_bytes) ? `DPC_RESET_VAL : prog_sum[15:0];
        end
        if (st.match) begin
            s_nxt.src_ptr = `DPC_RESET_VAL;
            s_nxt.cell_prog = `DPC_RESET_VAL;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign st.src_ptr = s_r.src_ptr;
    assign st.dst_ptr = s_r.dst_ptr;
    assign st.cell_prog = s_r.cell_prog;
    assign st.cell_done = st.xfer && !st.match && (prog_sum >= cell_bytes);

    chk_match_clears: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st.match |=> s_r.src_ptr == 16'h0000 && s_r.cell_prog == 16'h0000)
        else $error("match did not clear pointers");
    chk_dst_advance: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st.xfer |=> s_r.dst_ptr == $past(s_r.dst_ptr) + {13'h0000, $past(st.xfer_bytes)})
        else $error("destination pointer did not advance");
    chk_src_advance: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st.xfer && !st.match |=> s_r.src_ptr == $past(s_r.src_ptr) + {13'h0000, $past(st.xfer_bytes)})
        else $error("source pointer did not advance");
    chk_cell_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st.cell_done |=> s_r.cell_prog == 16'h0000)
        else $error("progress not cleared after full cell");
    chk_trig_clear: assert property (@(posedge pclk) disable iff (!presetn)
        ce && st.trigger && !st.xfer |=> s_r.cell_prog == 16'h0000)
        else $error("progress not cleared by trigger");
    chk_hold_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !ce |=> $stable(s_r))
        else $error("state moved while disabled");
    cov_cell_done: cover property (@(posedge pclk) disable iff (!presetn) ce && st.cell_done);
    cov_match: cover property (@(posedge pclk) disable iff (!presetn) ce && st.match && s_r.src_ptr != 16'h0000);
    cov_big_cell: cover property (@(posedge pclk) disable iff (!presetn) st.cell_size == 16'h0000 && st.xfer);
endmodule

// File: bench/dpc_bus_model.sv
`timescale 1ns/1ps
module dpc_bus_model (
    input  wire logic       pclk,       // Clock
    input  wire logic       presetn,    // Async reset, low
    input  wire logic       req,        // Bench asks for one transfer
    input  wire logic [2:0] req_bytes,  // Size wanted, 1 to 4
    input  wire logic [7:0] req_data,   // Byte to carry
    output logic            xfer,       // Transfer done pulse
    output logic      [2:0] xfer_bytes, // Bytes moved
    output logic      [7:0] rd_byte     // Byte read from source
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer       <= 1'b0;
            xfer_bytes <= 3'h0;
            rd_byte    <= 8'h00;
        end else begin
            xfer       <= req;
            xfer_bytes <= req ? req_bytes : 3'h0;
            // Data line toggles between transfers so no stale byte can pass for a match
            rd_byte    <= req ? req_data : ~rd_byte;
        end
    end
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, trigger, req, pready, pslverr, e;
    logic        xfer, pat_match, cell_complete;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [2:0]  req_bytes, xfer_bytes;
    logic [7:0]  req_data, rd_byte, match_byte_o;
    int          fails, checked, cyc, n_cc, n_pm;

    dpc_top dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .xfer(xfer),
        .xfer_bytes(xfer_bytes), .trigger(trigger), .rd_byte(rd_byte), .pat_match(pat_match),
        .cell_complete(cell_complete), .match_byte_o(match_byte_o));
    dpc_bus_model part_u (.pclk(pclk), .presetn(presetn), .req(req), .req_bytes(req_bytes),
        .req_data(req_data), .xfer(xfer), .xfer_bytes(xfer_bytes), .rd_byte(rd_byte));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        n_cc += (cell_complete === 1'b1);
        n_pm += (pat_match === 1'b1);
        if (cyc >= 3000) begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (fails == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Look mid-cycle so the ready pulse is read settled; pready ends this wait, or the bench timeout if it never rises
        do begin
            @(negedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        cmp(r, exp);
    endtask

    task automatic mv(input logic [2:0] b, input logic [7:0] d);
        @(posedge pclk);
        req       <= 1'b1;
        req_bytes <= b;
        req_data  <= d;
        @(posedge pclk);
        req <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, trigger, req, paddr, pwdata, req_data} = '0;
        req_bytes = 3'h1;
        {fails, checked, cyc, n_cc, n_pm} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(12'(4 * i), 32'h0000_0000);
        apb(1'b1, 12'h008, 32'hFFFF_0008);
        rd(12'h008, 32'h0000_0008);
        apb(1'b1, 12'h000, 32'h0000_1234);
        rd(12'h000, 32'h0000_0000);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        cmp({31'h0, e}, 32'h0000_0001);
        mv(3'h4, 8'h11);
        rd(12'h000, 32'h0000_0004);
        rd(12'h004, 32'h0000_0004);
        rd(12'h00C, 32'h0000_0004);
        mv(3'h4, 8'h22);
        rd(12'h00C, 32'h0000_0000);
        cmp(32'(n_cc), 32'h0000_0001);
        mv(3'h3, 8'h33);
        rd(12'h00C, 32'h0000_0003);
        @(posedge pclk);
        trigger <= 1'b1;
        @(posedge pclk);
        trigger <= 1'b0;
        rd(12'h00C, 32'h0000_0000);
        apb(1'b1, 12'h010, 32'h0000_00A5);
        apb(1'b1, 12'h014, 32'h0000_0001);
        cmp({24'h0, match_byte_o}, 32'h0000_00A5);
        mv(3'h2, 8'h5A);
        rd(12'h000, 32'h0000_000D);
        mv(3'h2, 8'hA5);
        rd(12'h000, 32'h0000_0000);
        rd(12'h00C, 32'h0000_0000);
        rd(12'h004, 32'h0000_000F);
        cmp(32'(n_pm), 32'h0000_0001);
        apb(1'b1, 12'h014, 32'h0000_0000);
        apb(1'b1, 12'h008, 32'h0000_0000);
        mv(3'h4, 8'hA5);
        rd(12'h00C, 32'h0000_0004);
        cmp(32'(n_cc), 32'h0000_0001);
        complete_run();
    end
endmodule
